// File: src/clock_select_gated_fanout.sv
// two-input clock selector with edge-synchronised gate and five output pairs
`timescale 1ns/1ps
`include "clock_select_defines.svh"

module clock_select_gated_fanout #(
  parameter int PAIRS = `FANOUT_PAIRS
) (
  // system
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_b_i,
  // clock inputs
  input  wire logic                                   diff_clock_in_p_i,
  input  wire logic                                   diff_clock_in_n_i,
  input  wire logic                                   single_ended_clock_in_i,
  // board controls, undriven reads as low
  input  wire logic                                   source_sel_i,
  input  wire logic                                   output_gate_n_i,
  // fanout
  output logic [PAIRS-1:0]                            fanout_true_o,
  output logic [PAIRS-1:0]                            fanout_complement_o
);

  // elaboration check: the fanout needs at least one output pair
  if (PAIRS < 1) begin : gen_pairs_check
    $error("PAIRS must be at least 1");
  end

  // three-stage synchronisers for every asynchronous input
  logic [2:0] diff_p_sync_ff;
  logic [2:0] diff_n_sync_ff;
  logic [2:0] single_sync_ff;
  logic [2:0] sel_sync_ff;
  logic [2:0] gate_sync_ff;
  logic [2:0] nxt_diff_p_sync;
  logic [2:0] nxt_diff_n_sync;
  logic [2:0] nxt_single_sync;
  logic [2:0] nxt_sel_sync;
  logic [2:0] nxt_gate_sync;

  // settled levels, updated once stages two and three agree
  logic                          diff_lvl_ff;
  logic                          single_lvl_ff;
  clock_select_pkg::control_type ctrl_ff;
  logic                          nxt_diff_lvl;
  logic                          nxt_single_lvl;
  clock_select_pkg::control_type nxt_ctrl;

  // selected clock and its previous level, for falling edge detect
  logic sel_clk;
  logic sel_clk_prev_ff;
  logic nxt_sel_clk_prev;
  logic fall_edge;

  // gate state applied to every pair
  logic gate_on_ff;
  logic nxt_gate_on;

  // output flops
  clock_select_pkg::fanout_pair_type [PAIRS-1:0] pair_ff;
  clock_select_pkg::fanout_pair_type [PAIRS-1:0] nxt_pair;

  // shift chains; stage 0 feeds only stage 1
  always_comb begin
    nxt_diff_p_sync = {diff_p_sync_ff[1:0], diff_clock_in_p_i};
    nxt_diff_n_sync = {diff_n_sync_ff[1:0], diff_clock_in_n_i};
    nxt_single_sync = {single_sync_ff[1:0], single_ended_clock_in_i};
    nxt_sel_sync    = {sel_sync_ff[1:0], source_sel_i};
    nxt_gate_sync   = {gate_sync_ff[1:0], output_gate_n_i};
  end

  // accept a level only when the last two stages agree
  always_comb begin
    nxt_diff_lvl   = diff_lvl_ff;
    nxt_single_lvl = single_lvl_ff;
    nxt_ctrl       = ctrl_ff;
    // differential input: a crossing counts when both legs agree it
    if ((diff_p_sync_ff[1] == diff_p_sync_ff[2]) &&
        (diff_n_sync_ff[1] == diff_n_sync_ff[2]) &&
        (diff_p_sync_ff[2] != diff_n_sync_ff[2])) begin
      nxt_diff_lvl = diff_p_sync_ff[2];
    end
    if (single_sync_ff[1] == single_sync_ff[2]) begin
      nxt_single_lvl = single_sync_ff[2];
    end
    if (sel_sync_ff[1] == sel_sync_ff[2]) begin
      nxt_ctrl.source_sel = sel_sync_ff[2];
    end
    if (gate_sync_ff[1] == gate_sync_ff[2]) begin
      nxt_ctrl.output_gate_n = gate_sync_ff[2];
    end
  end

  // source mux
  always_comb begin
    if (ctrl_ff.source_sel == `SEL_SINGLE_ENDED) begin
      sel_clk = single_lvl_ff;
    end else begin
      sel_clk = diff_lvl_ff;
    end
    nxt_sel_clk_prev = sel_clk;
    fall_edge        = sel_clk_prev_ff & ~sel_clk;
  end

  // gate takes its new state only on a falling edge of the selected clock,
  // when the output is already low, so no pulse is ever cut short
  always_comb begin
    nxt_gate_on = gate_on_ff;
    if (fall_edge) begin
      nxt_gate_on = (ctrl_ff.output_gate_n == `GATE_ENABLED);
    end
  end

  // output pairs, all from one clock and one gate
  genvar g;
  generate
    for (g = 0; g < PAIRS; g++) begin : gen_pair
      // one driver per bit: open gate follows the clock, closed gate parks low/high
      assign nxt_pair[g].true_out = gate_on_ff ? sel_clk : 1'b0;
      assign nxt_pair[g].comp_out = gate_on_ff ? ~sel_clk : 1'b1;
      assign fanout_true_o[g]       = pair_ff[g].true_out;
      assign fanout_complement_o[g] = pair_ff[g].comp_out;
    end
  endgenerate

  // registers; reset state is differential source, outputs enabled
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      diff_p_sync_ff  <= 3'h0;
      diff_n_sync_ff  <= 3'h0;
      single_sync_ff  <= 3'h0;
      sel_sync_ff     <= 3'h0;
      gate_sync_ff    <= 3'h0;
      diff_lvl_ff     <= 1'b0;
      single_lvl_ff   <= 1'b0;
      ctrl_ff         <= '0;
      sel_clk_prev_ff <= 1'b0;
      gate_on_ff      <= 1'b1;
      for (int i = 0; i < PAIRS; i++) begin
        pair_ff[i] <= 2'h1;
      end
    end else begin
      diff_p_sync_ff  <= nxt_diff_p_sync;
      diff_n_sync_ff  <= nxt_diff_n_sync;
      single_sync_ff  <= nxt_single_sync;
      sel_sync_ff     <= nxt_sel_sync;
      gate_sync_ff    <= nxt_gate_sync;
      diff_lvl_ff     <= nxt_diff_lvl;
      single_lvl_ff   <= nxt_single_lvl;
      ctrl_ff         <= nxt_ctrl;
      sel_clk_prev_ff <= nxt_sel_clk_prev;
      gate_on_ff      <= nxt_gate_on;
      pair_ff         <= nxt_pair;
    end
  end

  // gate only changes on a falling edge of the selected clock
  chk_gate_on_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $changed(gate_on_ff) |-> $past(fall_edge))
    else $error("gate changed without falling edge");

  // disabled outputs are forced to low and high
  chk_disabled_level: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !$past(gate_on_ff) |-> (fanout_true_o == '0) && (fanout_complement_o == '1))
    else $error("disabled outputs not forced");

  // the enabled true output of pair 0 follows the selected clock without inversion
  chk_enabled_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $past(gate_on_ff) |-> fanout_true_o[0] == $past(sel_clk))
    else $error("enabled output does not follow clock");

  // pairs are complementary
  chk_pair_compl: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    fanout_true_o == ~fanout_complement_o)
    else $error("pair not complementary");

  // all pairs identical
  chk_pairs_equal: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    fanout_true_o == {PAIRS{fanout_true_o[0]}})
    else $error("pairs differ");

  // with the gate open the output shows the settled level of the chosen source
  chk_source_mux: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $past(gate_on_ff) |->
      fanout_true_o[0] == ($past(ctrl_ff.source_sel) ? $past(single_lvl_ff)
                                                      : $past(diff_lvl_ff)))
    else $error("wrong source selected");

  // a true output never rises straight after the gate opens mid-high
  chk_no_runt: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(gate_on_ff) |-> fanout_true_o[0] == 1'b0)
    else $error("runt pulse at enable");

  // enabling only after gate input settled low
  chk_enable_cause: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(gate_on_ff) |-> $past(ctrl_ff.output_gate_n) == 1'b0)
    else $error("enabled without low gate");

  // the gate closes only while the output is already low, so no high is cut
  chk_no_cut_close: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(gate_on_ff) |-> fanout_true_o[0] == 1'b0)
    else $error("high pulse cut at disable");

  // closing needs the settled gate input to read high
  chk_disable_cause: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(gate_on_ff) |-> $past(ctrl_ff.output_gate_n) == 1'b1)
    else $error("disabled without high gate");

  // the settled gate level moves only once stages two and three agree on it
  chk_gate_sync_agree: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $changed(ctrl_ff.output_gate_n) |->
      ($past(gate_sync_ff[1]) == $past(gate_sync_ff[2])) &&
      ($past(gate_sync_ff[2]) == ctrl_ff.output_gate_n))
    else $error("gate level taken before synchroniser agreed");

endmodule

// File: src/clock_select_defines.svh
// constants for the clock selector with gated fanout
`ifndef CLOCK_SELECT_DEFINES_SVH
`define CLOCK_SELECT_DEFINES_SVH
`define FANOUT_PAIRS       5
`define SEL_SINGLE_ENDED   1'b1
`define SEL_DIFFERENTIAL   1'b0
`define GATE_ENABLED       1'b0
`define SYNC_STAGES        3
`endif

// File: src/clock_select_pkg.sv
// types for the clock selector with gated fanout
package clock_select_pkg;
  // one complementary output pair
  typedef struct packed {
    logic true_out;
    logic comp_out;
  } fanout_pair_type;
  // synchronised control inputs
  typedef struct packed {
    logic source_sel;
    logic output_gate_n;
  } control_type;
endpackage

// File: sim/clock_source_model.sv
// clock source model driving both inputs of the clock selector
`timescale 1ns/1ps
module clock_source_model #(
  parameter int DIFF_HALF = 80,  // half of the 160 ns link period
  parameter int SE_HALF   = 160  // slower rate so the two sources differ
) (
  // clock legs
  output logic diff_p_o,
  output logic diff_n_o,
  output logic single_o
);
  // free-running sources; legs kept opposite so the pair is always valid
  initial begin
    diff_p_o = 1'b0;
    single_o = 1'b0;
  end
  always #(DIFF_HALF) diff_p_o = ~diff_p_o;
  always #(SE_HALF) single_o = ~single_o;
  assign diff_n_o = ~diff_p_o;
endmodule

// File: sim/tb_top.sv
// self-checking bench for the clock selector with gated fanout
`timescale 1ns/1ps
module tb_top;
  localparam int PAIRS = 5;         // output pairs under test
  localparam int WIN   = 96;        // cycles in one measurement window
  logic             sys_clk_i = 1'b0;
  logic             rst_b_i = 1'b0;
  logic             diff_p;          // differential true leg
  logic             diff_n;          // differential inverted leg
  logic             single_se;       // single-ended source
  logic             source_sel_i = 1'b0;    // low, as when undriven
  logic             output_gate_n_i = 1'b0; // low, as when undriven
  logic [PAIRS-1:0] fanout_true_o;
  logic [PAIRS-1:0] fanout_complement_o;
  int               err_count = 0;
  int               num_checks = 0;
  int               edges = 0;       // rising edges seen on pair 0
  int               start = 0;       // edge count at window start
  int               run = 0;         // cycles of the current high run
  logic             win_done = 1'b0; // strobe: a window has closed
  int               exp_q[$];        // expected edge counts, oldest first

  always #10 sys_clk_i = ~sys_clk_i;

  clock_source_model i_clock_source_model (
    .diff_p_o(diff_p),
    .diff_n_o(diff_n),
    .single_o(single_se)
  );

  clock_select_gated_fanout #(.PAIRS(PAIRS)) i_clock_select_gated_fanout (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .diff_clock_in_p_i(diff_p),
    .diff_clock_in_n_i(diff_n),
    .single_ended_clock_in_i(single_se),
    .source_sel_i(source_sel_i),
    .output_gate_n_i(output_gate_n_i),
    .fanout_true_o(fanout_true_o),
    .fanout_complement_o(fanout_complement_o)
  );

  // one comparison, counted, reported on mismatch
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // single place where the run ends
  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // every cycle, on the falling edge where outputs are settled: pairs identical
  // and complementary, no short high pulse
  always @(negedge sys_clk_i) begin
    if (rst_b_i) begin
      check("pairs_equal", {PAIRS{fanout_true_o[0]}}, fanout_true_o);
      check("complement", PAIRS'(~fanout_true_o), fanout_complement_o);
      if (fanout_true_o[0] === 1'b1) begin
        run <= run + 1;
        if (run == 0) edges <= edges + 1;
      end else begin
        if (run != 0) check("high_run_ok", 1, run >= 3);
        run <= 0;
      end
    end
  end

  // a closed window is judged against the oldest note; phase allows one edge
  always @(posedge win_done) begin
    check("edge_count", 1, (edges - start + 1 >= exp_q[0]) && (edges - start <= exp_q[0] + (exp_q[0] != 0)));
    void'(exp_q.pop_front());
  end

  // each select and gate pair, then again after random gate chatter
  initial begin
    void'($urandom(21));
    repeat (12) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      // close the gate before switching: a source switch is not glitch-protected
      @(posedge sys_clk_i);
      #1 output_gate_n_i = 1'b1;
      repeat (30) @(posedge sys_clk_i);
      #1 source_sel_i = i[0];
      repeat (10) @(posedge sys_clk_i);
      #1 output_gate_n_i = i[1];
      // even number of toggles, so the gate settles at the table value
      if (i >= 4) repeat (6) begin
        repeat ($urandom_range(20, 4)) @(posedge sys_clk_i);
        #1 output_gate_n_i = ~output_gate_n_i;
      end
      repeat (40) @(posedge sys_clk_i);
      start = edges;
      exp_q.push_back(i[1] ? 0 : (i[0] ? WIN / 16 : WIN / 8));
      repeat (WIN) @(posedge sys_clk_i);
      #1 win_done = 1'b1;
      @(posedge sys_clk_i);
      #1 win_done = 1'b0;
    end
    tally_and_finish();
  end

  // watchdog well beyond the expected run time
  initial begin
    #100us;
    err_count++;
    tally_and_finish();
  end
endmodule
